//--- inc/adr_map.svh
`ifndef ADR_MAP_SVH
`define ADR_MAP_SVH
// Register word indices (printed offset 0x7 is not word aligned: index kept)
`define ADR_IDX_ROUTE      4'h7
`define ADR_IDX_FORMAT     4'h3
`define ADR_IDX_CTRL       4'h8
`define ADR_IDX_STATUS     4'h9
// Route register fields
`define ADR_ROUTE_EN_BIT   0
`define ADR_ROUTE_DIR_BIT  1
`define ADR_ROUTE_RST      4'h0
// Format codes
`define ADR_FMT_ROM_I2S    4'ha
`define ADR_FMT_ROM_EIAJ   4'hb
`define ADR_FMT_I2S_1FS    4'he
`define ADR_FMT_EIAJ16_1FS 4'h2
`define ADR_FMT_EIAJ18_1FS 4'h6
`define ADR_FMT_EIAJ16_4FS 4'h0
`define ADR_FMT_EIAJ18_4FS 4'h4
`define ADR_FMT_I2S18_4FS  4'hc
`define ADR_FMT_EIAJ16_2FS 4'h3
`define ADR_FMT_EIAJ18_2FS 4'h7
`define ADR_FMT_I2S18_2FS  4'hf
`define ADR_FMT_RST        4'he
// Control register fields
`define ADR_CTRL_WINV_BIT  0
`define ADR_CTRL_DINV_BIT  1
`define ADR_CTRL_EXT_BIT   2
`define ADR_CTRL_LTD_BIT   3
`define ADR_CTRL_SPD_LSB   4
// Timing: bit clock 2.1168 MHz nominal at 1fs, 64 bit slots per word pair
`define ADR_SLOTS_1FS      7'd64
`define ADR_DAC_OSR        96
`endif

//--- inc/adr_pkg.sv
package adr_pkg;
   typedef enum logic [2:0] {
      ADR_ROUTE_EXT  = 3'b001,
      ADR_ROUTE_LOOP = 3'b010,
      ADR_ROUTE_DIR  = 3'b100
   } adr_route_e;
   typedef enum logic [1:0] {
      ADR_AX_IDLE = 2'b01,
      ADR_AX_RESP = 2'b10
   } adr_axi_e;
   typedef logic [17:0] adr_sample_t;
endpackage

//--- tb/adr_audio_route_chk.sv
`timescale 1ns/1ps
// Bus handshakes and DAC side outputs, seen from the top ports
module adr_audio_route_chk (
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic        clkEn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        serBitClkOe,
   input wire logic        serWordClkOe,
   input wire logic        serDataOe,
   input wire logic        errorFlagOe,
   input wire logic [15:0] dac_left_pos_out,
   input wire logic [15:0] dac_left_neg_out,
   input wire logic        dacSampleStb,
   input wire logic        dacOsrClkEn
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   logic [6:0] gapCnt;
   logic       gapSeen;
   // Period count only trusted once a first pulse was seen
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         gapCnt  <= 7'h00;
         gapSeen <= 1'b0;
      end else if (dacOsrClkEn) begin
         gapCnt  <= 7'h00;
         gapSeen <= 1'b1;
      end else if (clkEn) begin
         gapCnt <= gapCnt + 7'h01;
      end
   end
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped");
   err_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
      |-> s_axi_rdata == 32'h0) else $error("error read data not zero");
   oe_group_a: assert property (serBitClkOe == serWordClkOe && serBitClkOe == serDataOe
      && serBitClkOe == errorFlagOe) else $error("serial enables split");
   dac_neg_a: assert property (dac_left_pos_out != 16'h0
      |-> dac_left_neg_out == ~dac_left_pos_out) else $error("dac pair mismatch");
   osr_period_a: assert property (gapSeen && dacOsrClkEn |-> gapCnt == 7'd95)
      else $error("oversampling period wrong");
   stb_pulse_a: assert property ($rose(dacSampleStb) |=> !dacSampleStb)
      else $error("sample strobe too long");
   loop_c: cover property (dacSampleStb);
   tri_c: cover property ($fell(serDataOe));
   slverr_c: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // adr_audio_route_chk

//--- tb/adr_esa_model.sv
`timescale 1ns/1ps
// Shock buffer chip feeding the loop-back input, I2S style 16-bit 1fs
module adr_esa_model (
   output logic loop_bit_clock_in,
   output logic loop_word_clock_in,
   output logic loop_serial_data_in
);
   initial begin
      loop_bit_clock_in   = 1'b0;
      loop_word_clock_in  = 1'b0;
      loop_serial_data_in = 1'b0;
   end
   // Clock runs only inside a frame; data one bit behind word clock
   task automatic sendPair(input logic [15:0] l, input logic [15:0] r);
      logic [33:0] s;
      s = {1'b0, l, r, 1'b0};
      for (int k = 0; k < 34; k++) begin
         loop_word_clock_in  = (k >= 16 && k < 32);
         loop_serial_data_in = s[33 - k];
         #7.5 loop_bit_clock_in = 1'b1;
         #7.5 loop_bit_clock_in = 1'b0;
      end
      // Released line must not keep the last bit
      loop_serial_data_in = ~loop_serial_data_in;
   endtask
endmodule // adr_esa_model

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic clock, arst_n, clkEn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, audioValid, audioErr, levelActive, serBitClkOut, serBitClkOe;
   logic serWordClkOut, serWordClkOe, serDataOut, serDataOe, error_flag_output;
   logic errorFlagOe, interpEnable, dacSampleStb, dacOsrClkEn;
   logic loop_bit_clock_in, loop_word_clock_in, loop_serial_data_in;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [17:0] audioLeft, audioRight;
   logic [15:0] dac_left_pos_out, dac_left_neg_out, dac_right_pos_out, dac_right_neg_out;
   logic [7:0]  rows [11] = '{8'ha6, 8'hb6, 8'hea, 8'h2a, 8'h6b, 8'h08, 8'h49, 8'hc9,
                              8'h38, 8'h79, 8'hf9};
   int          error_cnt = 0;
   int          tests_run = 0;
   int          toggles, ltdCnt;
   adr_audio_route DUT (.*);
   adr_esa_model   partner (.*);
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // Decoded audio, one stereo pair every 200 clocks
   initial begin
      {audioValid, audioLeft, audioRight} = '0;
      forever begin
         repeat (199) @(posedge clock);
         audioValid <= 1'b1;
         audioLeft  <= audioLeft + 18'h09a31;
         audioRight <= audioRight + 18'h05c07;
         @(posedge clock);
         audioValid <= 1'b0;
      end
   end
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // Bit clock changes over 400 clocks, after a short settling gap
   task automatic countBclk(output int n);
      logic prev;
      repeat (4) @(posedge clock);
      prev = serBitClkOut;
      n = 0;
      repeat (400) begin
         @(posedge clock);
         n += (serBitClkOut !== prev);
         prev = serBitClkOut;
      end
   endtask
   task automatic axiWr(input logic [31:0] a, d, input logic [3:0] s);
      logic awOk, wOk;
      {awOk, wOk} = 2'b00;
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      while (!(awOk && wOk)) begin
         @(posedge clock);
         if (s_axi_awvalid && s_axi_awready) begin awOk = 1; s_axi_awvalid <= 1'b0; end
         if (s_axi_wvalid && s_axi_wready) begin wOk = 1; s_axi_wvalid <= 1'b0; end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge clock);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clock);
   endtask
   task automatic axiRd(input logic [31:0] a);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do @(posedge clock); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge clock);
      {rd, rs} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
      @(posedge clock);
   endtask
   task automatic summarize();
      $display("Checks run %0d, errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Hang guard, far beyond the expected run
   initial begin
      #400_000;
      error_cnt++;
      summarize();
   end
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
      {audioErr, levelActive} = 2'h0;
      {arst_n, clkEn} = 2'b01;
      repeat (10) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      axiRd(32'h1c); chk("route reset", rd, 32'h0);
      axiRd(32'h0c); chk("format reset", rd, 32'he);
      chk("oe reset", serDataOe, 1'b1);
      // Every format code, readback and derived flags
      foreach (rows[i]) begin
         axiWr(32'h0c, {28'h0, rows[i][7:4]}, 4'hf);
         axiRd(32'h0c); chk("format", rd, {28'h0, rows[i][7:4]});
         chk("interp", interpEnable, rows[i][3]);
         axiRd(32'h24); chk("status", rd[2:0], rows[i][2:0]);
      end
      axiWr(32'h0c, 32'he, 4'hf);
      levelActive <= 1'b1;
      repeat (2) @(posedge clock);
      axiRd(32'h24); chk("i2s 18bit", rd[0], 1'b1);
      levelActive <= 1'b0;
      // External DAC: serial port runs, DAC held at zero
      countBclk(toggles);
      chk("ser active", toggles > 0, 1'b1);
      chk("dac zero", dac_left_pos_out, 16'h0);
      // Lock-to-disc at double speed must double the bit clock rate
      axiWr(32'h20, 32'h18, 4'hf);
      countBclk(ltdCnt);
      chk("ltd rate", ltdCnt, 2 * toggles);
      axiWr(32'h20, 32'h0, 4'hf);
      // Error flag follows the decoder flag at 1fs, stays low at 2fs
      audioErr <= 1'b1;
      repeat (300) @(posedge clock);
      chk("flag 1fs", error_flag_output, 1'b1);
      axiWr(32'h0c, 32'h3, 4'hf);
      repeat (20) @(posedge clock);
      chk("flag 2fs", error_flag_output, 1'b0);
      audioErr <= 1'b0;
      axiWr(32'h0c, 32'he, 4'hf);
      axiWr(32'h1c, 32'h3, 4'hf);
      repeat (400) @(posedge clock);
      chk("oe direct", {serBitClkOe, serDataOe, errorFlagOe}, 3'b000);
      chk("dac fed", dac_left_pos_out != 16'h0, 1'b1);
      axiWr(32'h1c, 32'h1, 4'hf);
      repeat (2) @(posedge clock);
      chk("oe loop", serWordClkOe, 1'b1);
      fork
         partner.sendPair(16'h1234, 16'hc5a9);
         begin
            do @(posedge clock); while (dacSampleStb !== 1'b1);
            chk("loop left", dac_left_pos_out, 16'h1234);
            chk("loop right", dac_right_pos_out, 16'hc5a9);
            chk("loop neg", dac_right_neg_out, 16'h3a56);
         end
      join
      // Awkward accesses: no byte strobe, unmapped index
      axiWr(32'h1c, 32'h0, 4'h0); chk("nostrb resp", rs, 2'h0);
      axiRd(32'h1c); chk("nostrb keep", rd, 32'h1);
      axiWr(32'h40, 32'h5, 4'hf); chk("unmapped wr", rs, 2'h2);
      axiRd(32'h40); chk("unmapped rd", {rd, rs}, {32'h0, 2'h2});
      axiWr(32'h20, 32'h3, 4'hf);
      axiRd(32'h20); chk("ctrl inv", rd[1:0], 2'h3);
      // Reset in mid-run returns routing to the zero-output default
      arst_n <= 1'b0;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      axiRd(32'h1c); chk("route rerst", rd, 32'h0);
      chk("dac rerst", dac_left_pos_out, 16'h0);
      summarize();
   end
endmodule // tb_top
bind adr_audio_route adr_audio_route_chk chk_i (.*);

//--- verilog/adr_audio_route.sv
`timescale 1ns/1ps
`include "adr_map.svh"
module adr_audio_route #(
   parameter int SPEED_W = 2
) (
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic        clkEn,
   // AXI4-Lite slave
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Decoded audio from the decoder, one stereo pair per strobe
   input  wire logic        audioValid,
   input  wire logic [17:0] audioLeft,
   input  wire logic [17:0] audioRight,
   input  wire logic        audioErr,
   input  wire logic        levelActive,
   // Serial output port
   output logic             serBitClkOut,
   output logic             serBitClkOe,
   output logic             serWordClkOut,
   output logic             serWordClkOe,
   output logic             serDataOut,
   output logic             serDataOe,
   output logic             error_flag_output,
   output logic             errorFlagOe,
   output logic             interpEnable,
   // Loop-back input port (own clock domain)
   input  wire logic        loop_bit_clock_in,
   input  wire logic        loop_word_clock_in,
   input  wire logic        loop_serial_data_in,
   // On-chip DAC sample interface
   output logic [15:0]      dac_left_pos_out,
   output logic [15:0]      dac_left_neg_out,
   output logic [15:0]      dac_right_pos_out,
   output logic [15:0]      dac_right_neg_out,
   output logic             dacSampleStb,
   output logic             dacOsrClkEn
);
   // Register state
   logic [3:0]         routeReg;
   logic [3:0]         formatReg;
   logic [7:0]         ctrlReg;
   adr_pkg::adr_axi_e  wrState;
   adr_pkg::adr_axi_e  rdState;
   logic               awHeld, wHeld;
   logic [3:0]         awIdx;
   logic [31:0]        wData;
   logic               wByte0;

   // Format decode
   logic fmtRom, fmt1fs, fmt2fs, fmtI2s, fmt18;
   always_comb begin
      fmtRom = (formatReg == `ADR_FMT_ROM_I2S) || (formatReg == `ADR_FMT_ROM_EIAJ);
      fmt1fs = fmtRom || (formatReg == `ADR_FMT_I2S_1FS) ||
               (formatReg == `ADR_FMT_EIAJ16_1FS) || (formatReg == `ADR_FMT_EIAJ18_1FS);
      fmt2fs = (formatReg == `ADR_FMT_EIAJ16_2FS) || (formatReg == `ADR_FMT_EIAJ18_2FS) ||
               (formatReg == `ADR_FMT_I2S18_2FS);
      fmtI2s = (formatReg == `ADR_FMT_ROM_I2S) || (formatReg == `ADR_FMT_I2S_1FS) ||
               (formatReg == `ADR_FMT_I2S18_4FS) || (formatReg == `ADR_FMT_I2S18_2FS);
      fmt18  = (formatReg == `ADR_FMT_EIAJ18_1FS) || (formatReg == `ADR_FMT_EIAJ18_4FS) ||
               (formatReg == `ADR_FMT_I2S18_4FS) || (formatReg == `ADR_FMT_EIAJ18_2FS) ||
               (formatReg == `ADR_FMT_I2S18_2FS) ||
               ((formatReg == `ADR_FMT_I2S_1FS) && levelActive);
   end

   adr_pkg::adr_route_e route;
   always_comb begin
      if (routeReg[`ADR_ROUTE_DIR_BIT])
         route = adr_pkg::ADR_ROUTE_DIR;
      else if (routeReg[`ADR_ROUTE_EN_BIT])
         route = adr_pkg::ADR_ROUTE_LOOP;
      else
         route = adr_pkg::ADR_ROUTE_EXT;
   end

   // AXI write channel: address and data accepted in either order
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wrState <= adr_pkg::ADR_AX_IDLE;
         {awHeld, wHeld} <= 2'h0;
         awIdx <= 4'h0;
         wData <= 32'h0;
         wByte0 <= 1'b0;
         {s_axi_bvalid, s_axi_bresp} <= 3'h0;
      end else if (clkEn) begin
         case (wrState)
            adr_pkg::ADR_AX_IDLE: begin
               if (s_axi_awvalid && !awHeld) begin
                  awHeld <= 1'b1;
                  awIdx <= s_axi_awaddr[5:2];
               end
               if (s_axi_wvalid && !wHeld) begin
                  wHeld <= 1'b1;
                  wData <= s_axi_wdata;
                  wByte0 <= s_axi_wstrb[0];
               end
               if (awHeld && wHeld) begin
                  wrState <= adr_pkg::ADR_AX_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= (awIdx == `ADR_IDX_ROUTE || awIdx == `ADR_IDX_FORMAT ||
                                  awIdx == `ADR_IDX_CTRL || awIdx == `ADR_IDX_STATUS)
                                 ? 2'b00 : 2'b10;
               end
            end
            adr_pkg::ADR_AX_RESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  {awHeld, wHeld} <= 2'h0;
                  wrState <= adr_pkg::ADR_AX_IDLE;
               end
            end
            default: wrState <= adr_pkg::ADR_AX_IDLE;
         endcase
      end
   end
   assign s_axi_awready = 1'b0 | (wrState == adr_pkg::ADR_AX_IDLE && !awHeld && arst_n);
   assign s_axi_wready  = (wrState == adr_pkg::ADR_AX_IDLE) && !wHeld && arst_n;

   // Register update on the cycle the write completes
   logic doWrite;
   assign doWrite = clkEn && (wrState == adr_pkg::ADR_AX_IDLE) && awHeld && wHeld && wByte0;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         routeReg <= `ADR_ROUTE_RST;
         formatReg <= `ADR_FMT_RST;
         ctrlReg <= 8'h00;
      end else if (doWrite) begin
         case (awIdx)
            `ADR_IDX_ROUTE:  routeReg <= wData[3:0];
            `ADR_IDX_FORMAT: formatReg <= wData[3:0];
            `ADR_IDX_CTRL:   ctrlReg <= wData[7:0];
            default:         ;
         endcase
      end
   end

   // AXI read channel
   logic loopLocked;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdState <= adr_pkg::ADR_AX_IDLE;
         {s_axi_rvalid, s_axi_rresp} <= 3'h0;
         s_axi_rdata <= 32'h0;
      end else if (clkEn) begin
         case (rdState)
            adr_pkg::ADR_AX_IDLE: begin
               if (s_axi_arvalid) begin
                  rdState <= adr_pkg::ADR_AX_RESP;
                  s_axi_rvalid <= 1'b1;
                  s_axi_rresp <= 2'b00;
                  case (s_axi_araddr[5:2])
                     `ADR_IDX_ROUTE:  s_axi_rdata <= {28'h0, routeReg};
                     `ADR_IDX_FORMAT: s_axi_rdata <= {28'h0, formatReg};
                     `ADR_IDX_CTRL:   s_axi_rdata <= {24'h0, ctrlReg};
                     `ADR_IDX_STATUS: s_axi_rdata <= {25'h0, loopLocked, route,
                                                      fmtRom, fmt1fs, fmt18};
                     default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'b10;
                     end
                  endcase
               end
            end
            adr_pkg::ADR_AX_RESP: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  rdState <= adr_pkg::ADR_AX_IDLE;
               end
            end
            default: rdState <= adr_pkg::ADR_AX_IDLE;
         endcase
      end
   end
   assign s_axi_arready = (rdState == adr_pkg::ADR_AX_IDLE) && arst_n;

   // Bit clock divider; lock-to-disc scales by speed factor
   logic [7:0] divCnt;
   logic [7:0] divLimit;
   logic [6:0] slotCnt;
   logic [6:0] slotsPerWord;
   logic [SPEED_W-1:0] speed;
   assign speed = ctrlReg[`ADR_CTRL_SPD_LSB +: SPEED_W];
   always_comb begin
      // Divider is coarse: clock ratio sets absolute rate, shape follows format
      divLimit = fmt1fs ? 8'd4 : (fmt2fs ? 8'd2 : 8'd1);
      if (ctrlReg[`ADR_CTRL_LTD_BIT])
         divLimit = 8'(divLimit >> speed);
      if (divLimit == 8'd0)
         divLimit = 8'd1;
      slotsPerWord = `ADR_SLOTS_1FS;
   end
   logic bitTick;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         divCnt <= 8'h0;
         bitTick <= 1'b0;
      end else if (clkEn) begin
         bitTick <= (divCnt == divLimit - 8'd1);
         divCnt <= (divCnt >= divLimit - 8'd1) ? 8'h0 : divCnt + 8'd1;
      end
   end

   // Serial shifter: MSB first, one stereo pair per 64 slots
   logic [35:0] shiftPair;
   logic        errHeld;
   logic        bclk;
   logic        drive;
   assign drive = (route != adr_pkg::ADR_ROUTE_DIR);
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         shiftPair <= 36'h0;
         slotCnt <= 7'h0;
         {bclk, errHeld} <= 2'h0;
         {serBitClkOut, serWordClkOut, serDataOut, error_flag_output} <= 4'h0;
      end else if (clkEn) begin
         if (audioValid) begin
            shiftPair <= {audioLeft, audioRight};
            errHeld <= audioErr;
         end
         if (bitTick) begin
            bclk <= ~bclk;
            serBitClkOut <= ~bclk;
            if (bclk) begin
               slotCnt <= (slotCnt == slotsPerWord - 7'd1) ? 7'h0 : slotCnt + 7'd1;
               // I2S data lags word clock by one slot; EIAJ MSB starts at the word clock edge
               serWordClkOut <= (fmtI2s ? (slotCnt >= 7'd31 && slotCnt < 7'd63)
                                       : slotCnt[5]) ^ ctrlReg[`ADR_CTRL_WINV_BIT];
               serDataOut <= shiftPair[{slotCnt[5] ? 6'd17 : 6'd35} -
                                       6'(slotCnt[4:0] % 5'd18)]
                             ^ ctrlReg[`ADR_CTRL_DINV_BIT];
               error_flag_output <= (fmt1fs) ? errHeld : 1'b0;
            end
         end
      end
   end

   // Output enables
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         {serBitClkOe, serWordClkOe, serDataOe, errorFlagOe} <= 4'h0;
         interpEnable <= 1'b0;
      end else if (clkEn) begin
         {serBitClkOe, serWordClkOe, serDataOe, errorFlagOe} <= {4{drive}};
         interpEnable <= !fmtRom;
      end
   end

   // Loop-back receiver on its own bit clock
   logic        lpWsPrev;
   logic [15:0] lpShift;
   logic [15:0] lpLeft, lpPairL, lpPairR;
   logic        lpToggle;
   logic        styleI2sA, styleI2sB;
   logic [15:0] lpWord;
   always_ff @(posedge loop_bit_clock_in or negedge arst_n) begin
      if (!arst_n) begin
         {styleI2sA, styleI2sB} <= 2'h0;
      end else begin
         styleI2sA <= fmtI2s;
         styleI2sB <= styleI2sA;
      end
   end
   always_ff @(posedge loop_bit_clock_in or negedge arst_n) begin
      if (!arst_n) begin
         {lpWsPrev, lpToggle} <= 2'h0;
         {lpShift, lpLeft, lpPairL, lpPairR} <= 64'h0;
      end else begin
         // Word clock edge frames each 16-bit word
         lpWsPrev <= loop_word_clock_in;
         lpShift <= {lpShift[14:0], loop_serial_data_in};
         if (lpWsPrev != loop_word_clock_in) begin
            // I2S: word ends on the edge bit itself; EIAJ right-justified at edge
            if (styleI2sB ? loop_word_clock_in : !loop_word_clock_in)
               lpLeft <= lpWord;
            else begin
               lpPairL <= lpLeft;
               lpPairR <= lpWord;
               lpToggle <= ~lpToggle;
            end
         end
      end
   end

   // I2S LSB arrives at the edge itself, so it must join the word here
   assign lpWord = styleI2sB ? {lpShift[14:0], loop_serial_data_in} : lpShift;

   // Toggle crossing; pair words are stable for a full word period
   logic lpTogA, lpTogB, lpTogC;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         {lpTogA, lpTogB, lpTogC} <= 3'h0;
         loopLocked <= 1'b0;
      end else if (clkEn) begin
         lpTogA <= lpToggle;
         lpTogB <= lpTogA;
         lpTogC <= lpTogB;
         if (lpTogB != lpTogC)
            loopLocked <= 1'b1;
      end
   end

   // DAC feed at 1fs, oversampling clock enable at 96 fs
   logic [6:0] osrCnt;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         {dac_left_pos_out, dac_left_neg_out, dac_right_pos_out, dac_right_neg_out} <= 64'h0;
         {dacSampleStb, dacOsrClkEn} <= 2'h0;
         osrCnt <= 7'h0;
      end else if (clkEn) begin
         dacSampleStb <= 1'b0;
         osrCnt <= (osrCnt == 7'(`ADR_DAC_OSR - 1)) ? 7'h0 : osrCnt + 7'd1;
         dacOsrClkEn <= (osrCnt == 7'h0);
         if (!routeReg[`ADR_ROUTE_EN_BIT]) begin
            {dac_left_pos_out, dac_left_neg_out} <= 32'h0;
            {dac_right_pos_out, dac_right_neg_out} <= 32'h0;
         end else if (route == adr_pkg::ADR_ROUTE_DIR && audioValid) begin
            dac_left_pos_out <= audioLeft[17:2];
            dac_left_neg_out <= ~audioLeft[17:2];
            dac_right_pos_out <= audioRight[17:2];
            dac_right_neg_out <= ~audioRight[17:2];
            dacSampleStb <= 1'b1;
         end else if (route == adr_pkg::ADR_ROUTE_LOOP && lpTogB != lpTogC) begin
            dac_left_pos_out <= lpPairL;
            dac_left_neg_out <= ~lpPairL;
            dac_right_pos_out <= lpPairR;
            dac_right_neg_out <= ~lpPairR;
            dacSampleStb <= 1'b1;
         end
      end
   end
endmodule // adr_audio_route
